//--- src/imtc_cfg.svh
`ifndef IMTC_CFG_SVH
`define IMTC_CFG_SVH
`define IMTC_BUS_UNKNOWN 2'h0
`define IMTC_BUS_IDLE 2'h1
`define IMTC_BUS_BUS_OWNED_STATE 2'h2
`define IMTC_BUS_BUSY 2'h3
`define IMTC_HS_FIXED 8'h02
`define IMTC_TEN_PREFIX 5'h1e
`define IMTC_CMD_NONE 2'h0
`define IMTC_CMD_RSTART 2'h1
`define IMTC_CMD_READ 2'h2
`define IMTC_CMD_STOP 2'h3
`define IMTC_SPEED_HS 2'h2
`endif

//--- src/imtc_pkg.sv
package imtc_pkg;
   typedef enum logic [9:0] {
      ST_IDLE = 10'h001,
      ST_WAIT = 10'h002,
      ST_START = 10'h004,
      ST_TXBIT = 10'h008,
      ST_RXACK = 10'h010,
      ST_RXBIT = 10'h020,
      ST_TXACK = 10'h040,
      ST_HOLD = 10'h080,
      ST_STOP = 10'h100,
      ST_LOST = 10'h200
   } imtc_state_t;
   typedef logic [1:0] imtc_cmd_t;
endpackage

//--- src/imtc_sync.sv
`timescale 1ns/100ps
`default_nettype none
module imtc_sync (
   input wire logic clk,
   input wire logic rst,
   input wire logic async_in,
   output logic sync_out
);
   logic meta_q;
   always_ff @(posedge clk) begin
      if (rst) begin
         meta_q <= 1'b1;
         sync_out <= 1'b1;
      end else begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule
`default_nettype wire

//--- src/imtc_buf2.sv
`timescale 1ns/100ps
`default_nettype none
module imtc_buf2 #(
   parameter int WIDTH = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   logic [WIDTH-1:0] mem_q [2];
   logic wr_q, rd_q;
   logic [1:0] cnt_q;
   logic push, pop;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign in_ready = (cnt_q != 2'h2);
   assign out_valid = (cnt_q != 2'h0);
   assign out_data = mem_q[rd_q];
   always_ff @(posedge clk) begin
      if (rst) begin
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         cnt_q <= 2'h0;
         mem_q[0] <= '0;
         mem_q[1] <= '0;
      end else begin
         if (push) begin
            mem_q[wr_q] <= in_data;
            wr_q <= ~wr_q;
         end
         if (pop) begin
            rd_q <= ~rd_q;
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + 2'h1;
         end else if (pop && !push) begin
            cnt_q <= cnt_q - 2'h1;
         end
      end
   end
endmodule
`default_nettype wire

//--- src/imtc_top.sv
// How it works
// - High-speed SCL is self-timed: 2+2*high or 2+high+low core cycles per period.
// - Address write starts a transaction; waits for idle or unknown bus, then start and address.
// - Address arbitration loss sets master flag and lost status, releases both lines.
// - Bus error acts like arbitration loss, also setting bus-error status.
// - Not-acknowledge status keeps the last acknowledge bit actually received.
// - Writing the address clears every master status and flag.
// - Unacknowledged address sets master flag and not-acknowledge, then holds clock.
// - Acked write address sets master flag, holds; data, address or stop continue.
// - Acked read address receives first byte, then sets slave flag and holds, except in smart mode with stretch mode 0.
// - Smart mode sends ACK or NACK automatically per acknowledge action.
// - Data transmit checks collisions; master flag is set whatever the outcome.
// - Stretch mode 0: NACK lost to arbitration sets master flag, not slave flag.
// - Stretch mode 1: slave flag rises only after byte and its acknowledge.
// - Master code 00001nnn goes at full speed with high-speed bit clear.
// - After master code, address with high-speed bit set runs at high speed.
// - Ten-bit enable sends two address bytes; direction bit must be zero.
// - Ten-bit NACK on first byte raises master flag; else after second byte.
// - Internal start from an idle bus moves bus state to bus_owned_state.
`timescale 1ns/100ps
`default_nettype none
`include "imtc_cfg.svh"
module imtc_top #(
   parameter int BAUD_W = 8,
   parameter int FS_HALF = 50
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic SCL_IN,
   output logic SCL_OUT,
   output logic SCL_OE,
   input wire logic SDA_IN,
   output logic SDA_OUT,
   output logic SDA_OE,
   input wire logic [BAUD_W-1:0] HS_BAUD_HIGH,
   input wire logic [BAUD_W-1:0] HS_BAUD_LOW_A,
   input wire logic [1:0] SPEED_SELECT,
   input wire logic STRETCH_MODE,
   input wire logic SMART_MODE,
   input wire logic ACK_ACTION,
   input wire logic ADDR_WRITE,
   input wire logic [10:0] ADDR_VALUE,
   input wire logic HIGH_SPEED_ADDRESS_BIT,
   input wire logic TEN_BIT_EN,
   input wire logic TX_VALID,
   output logic TX_READY,
   input wire logic [7:0] TX_DATA,
   output logic RX_VALID,
   input wire logic RX_READY,
   output logic [7:0] RX_DATA,
   input wire logic CMD_WRITE,
   input wire imtc_pkg::imtc_cmd_t CMD,
   output logic MASTER_ON_BUS,
   output logic SLAVE_ON_BUS,
   output logic ARB_LOST,
   output logic BUS_ERROR,
   output logic RX_NACK,
   output logic [1:0] BUS_STATE
);
   import imtc_pkg::*;
   ////////////////////////////////////////////////////////////////////////////
   logic scl_s, sda_s, scl_p, sda_p;
   imtc_sync u_scl (.clk(CLK), .rst(RST), .async_in(SCL_IN), .sync_out(scl_s));
   imtc_sync u_sda (.clk(CLK), .rst(RST), .async_in(SDA_IN), .sync_out(sda_s));
   logic start_det, stop_det;
   assign start_det = scl_s && scl_p && sda_p && !sda_s;
   assign stop_det = scl_s && scl_p && !sda_p && sda_s;
   // Received bytes pass through a two-entry buffer; a byte finished while it is full is dropped.
   logic rx_push, rx_ready, rx_ov, rx_or;
   logic [7:0] rx_byte_q, rx_od;
   imtc_buf2 #(.WIDTH(8)) u_rxbuf (.clk(CLK), .rst(RST), .in_valid(rx_push),
      .in_ready(rx_ready), .in_data(rx_byte_q), .out_valid(rx_ov), .out_ready(rx_or),
      .out_data(rx_od));
   assign rx_or = !RX_VALID || RX_READY;
   ////////////////////////////////////////////////////////////////////////////
   imtc_state_t st_q;
   logic [8:0] sh_q;
   logic [3:0] bit_q;
   logic [1:0] phase_q;
   logic [BAUD_W+1:0] tmr_q;
   logic hs_q, hs_pend_q, second_q, read_q, tail_q, ack_bit_q, ack_own_q;
   logic [7:0] addr2_q;
   logic tick, hs_on, want_tx, want_cmd;
   logic [BAUD_W+1:0] hi_len, lo_len, fs_len;
   assign fs_len = (BAUD_W+2)'(FS_HALF);
   // Fixed overhead split evenly; equal halves when the low field is zero.
   assign hi_len = (BAUD_W+2)'(HS_BAUD_HIGH) + (BAUD_W+2)'(1);
   assign lo_len = (HS_BAUD_LOW_A == '0) ? hi_len
                 : (BAUD_W+2)'(HS_BAUD_LOW_A) + (BAUD_W+2)'(1);
   assign hs_on = hs_q && (SPEED_SELECT == `IMTC_SPEED_HS);
   assign tick = (tmr_q == '0);
   assign want_tx = TX_VALID && TX_READY;
   assign want_cmd = CMD_WRITE && (CMD != `IMTC_CMD_NONE);
   assign rx_push = (st_q == ST_RXBIT) && tick && (phase_q == 2'h3) && (bit_q == 4'h7)
                    && rx_ready;
   ////////////////////////////////////////////////////////////////////////////
   // Bit engine: phase 0 SCL low set data, 1 SCL high, 2 sample, 3 low again.
   always_ff @(posedge CLK) begin
      if (RST) begin
         st_q <= ST_IDLE;
         sh_q <= '0;
         bit_q <= '0;
         phase_q <= '0;
         tmr_q <= '0;
         hs_q <= 1'b0;
         hs_pend_q <= 1'b0;
         second_q <= 1'b0;
         read_q <= 1'b0;
         tail_q <= 1'b0;
         ack_bit_q <= 1'b1;
         ack_own_q <= 1'b0;
         addr2_q <= '0;
         rx_byte_q <= '0;
         SCL_OE <= 1'b0;
         SDA_OE <= 1'b0;
         MASTER_ON_BUS <= 1'b0;
         SLAVE_ON_BUS <= 1'b0;
         ARB_LOST <= 1'b0;
         BUS_ERROR <= 1'b0;
         RX_NACK <= 1'b0;
         TX_READY <= 1'b0;
      end else begin
         TX_READY <= (st_q == ST_HOLD) && !read_q && !TX_READY;
         if (!tick) begin
            tmr_q <= tmr_q - (BAUD_W+2)'(1);
         end
         if (ADDR_WRITE) begin
            // Fresh transaction clears all master flags.
            MASTER_ON_BUS <= 1'b0;
            SLAVE_ON_BUS <= 1'b0;
            ARB_LOST <= 1'b0;
            BUS_ERROR <= 1'b0;
            RX_NACK <= 1'b0;
            hs_pend_q <= HIGH_SPEED_ADDRESS_BIT;
            second_q <= 1'b0;
            // Ten-bit: prefix byte first, low address byte after.
            sh_q <= TEN_BIT_EN ? {`IMTC_TEN_PREFIX, ADDR_VALUE[10:9], 1'b0, 1'b1}
                               : {ADDR_VALUE[7:0], 1'b1};
            tail_q <= TEN_BIT_EN;
            addr2_q <= ADDR_VALUE[8:1];
            read_q <= !TEN_BIT_EN && ADDR_VALUE[0];
            st_q <= (st_q == ST_HOLD) ? ST_START : ST_WAIT;
            bit_q <= '0;
            phase_q <= '0;
         end else begin
            unique case (st_q)
               ST_IDLE: begin
                  SCL_OE <= 1'b0;
                  SDA_OE <= 1'b0;
               end
               ST_WAIT: begin
                  if (BUS_STATE == `IMTC_BUS_IDLE || BUS_STATE == `IMTC_BUS_UNKNOWN) begin
                     st_q <= ST_START;
                     tmr_q <= fs_len;
                  end
               end
               ST_START: begin
                  // Master code goes at full speed; high speed after.
                  if (tick) begin
                     tmr_q <= hs_on ? hi_len : fs_len;
                     phase_q <= phase_q + 2'h1;
                     unique case (phase_q)
                        2'h0: begin
                           SDA_OE <= 1'b0;
                           SCL_OE <= 1'b0;
                        end
                        2'h1: SDA_OE <= 1'b1;
                        2'h2: SCL_OE <= 1'b1;
                        default: begin
                           hs_q <= hs_pend_q;
                           st_q <= ST_TXBIT;
                           bit_q <= '0;
                        end
                     endcase
                  end
               end
               ST_TXBIT, ST_RXBIT, ST_TXACK, ST_RXACK: begin
                  if (tick) begin
                     phase_q <= phase_q + 2'h1;
                     // High-speed: one-cycle edges, so high is high+1 and low is low+1.
                     if (!hs_on) begin
                        tmr_q <= fs_len;
                     end else if (phase_q == 2'h1) begin
                        tmr_q <= hi_len - (BAUD_W+2)'(2);
                     end else if (phase_q == 2'h3) begin
                        tmr_q <= lo_len - (BAUD_W+2)'(2);
                     end else begin
                        tmr_q <= '0;
                     end
                     unique case (phase_q)
                        2'h0: begin
                           SCL_OE <= 1'b1;
                           SDA_OE <= (st_q == ST_TXBIT) ? !sh_q[8]
                                   : (st_q == ST_TXACK) ? !ack_bit_q : 1'b0;
                        end
                        2'h1: SCL_OE <= 1'b0;
                        2'h2: begin
                           // High-speed SCL is driven open-loop, so no wait here.
                           if (!scl_s && !hs_on) begin
                              phase_q <= 2'h2;
                              tmr_q <= '0;
                           end else if ((st_q == ST_TXBIT && sh_q[8] && !sda_s)
                                || (st_q == ST_TXACK && ack_bit_q && !sda_s)) begin
                              ARB_LOST <= 1'b1;
                              MASTER_ON_BUS <= 1'b1;
                              SCL_OE <= 1'b0;
                              SDA_OE <= 1'b0;
                              st_q <= ST_LOST;
                           end else if (st_q == ST_RXACK) begin
                              RX_NACK <= sda_s;
                              ack_own_q <= sda_s;
                           end else if (st_q == ST_RXBIT) begin
                              rx_byte_q <= {rx_byte_q[6:0], sda_s};
                           end
                        end
                        default: begin
                           SCL_OE <= 1'b1;
                           bit_q <= bit_q + 4'h1;
                           sh_q <= {sh_q[7:0], 1'b1};
                           if (st_q == ST_TXBIT && bit_q == 4'h7) begin
                              st_q <= ST_RXACK;
                           end else if (st_q == ST_RXBIT && bit_q == 4'h7) begin
                              if (STRETCH_MODE || SMART_MODE) begin
                                 st_q <= ST_TXACK;
                                 ack_bit_q <= ACK_ACTION;
                              end else begin
                                 SLAVE_ON_BUS <= 1'b1;
                                 st_q <= ST_HOLD;
                              end
                           end else if (st_q == ST_TXACK) begin
                              SDA_OE <= 1'b0;
                              if (STRETCH_MODE) begin
                                 SLAVE_ON_BUS <= 1'b1;
                                 st_q <= ST_HOLD;
                              end else if (!ack_bit_q) begin
                                 st_q <= ST_RXBIT;
                              end else begin
                                 st_q <= SMART_MODE ? ST_STOP : ST_HOLD;
                              end
                              bit_q <= '0;
                           end else if (st_q == ST_RXACK) begin
                              SDA_OE <= 1'b0;
                              bit_q <= '0;
                              if (!ack_own_q && tail_q) begin
                                 tail_q <= 1'b0;
                                 sh_q <= {addr2_q, 1'b1};
                                 st_q <= ST_TXBIT;
                              end else if (!ack_own_q && read_q && !second_q) begin
                                 second_q <= 1'b1;
                                 st_q <= ST_RXBIT;
                              end else begin
                                 MASTER_ON_BUS <= 1'b1;
                                 st_q <= ST_HOLD;
                              end
                           end
                        end
                     endcase
                  end
               end
               ST_HOLD: begin
                  SCL_OE <= 1'b1;
                  phase_q <= '0;
                  bit_q <= '0;
                  tmr_q <= fs_len;
                  if (want_tx && !read_q) begin
                     sh_q <= {TX_DATA, 1'b1};
                     MASTER_ON_BUS <= 1'b0;
                     st_q <= ST_TXBIT;
                  end else if (want_cmd) begin
                     MASTER_ON_BUS <= 1'b0;
                     SLAVE_ON_BUS <= 1'b0;
                     unique case (CMD)
                        `IMTC_CMD_STOP: st_q <= ST_STOP;
                        `IMTC_CMD_RSTART: st_q <= ST_START;
                        default: begin
                           if (read_q && STRETCH_MODE) begin
                              st_q <= ST_RXBIT;
                           end else if (read_q) begin
                              ack_bit_q <= ACK_ACTION;
                              st_q <= ST_TXACK;
                           end
                        end
                     endcase
                  end
               end
               ST_STOP: begin
                  if (tick) begin
                     tmr_q <= fs_len;
                     phase_q <= phase_q + 2'h1;
                     unique case (phase_q)
                        2'h0: SDA_OE <= 1'b1;
                        2'h1: SCL_OE <= 1'b0;
                        2'h2: SDA_OE <= 1'b0;
                        default: begin
                           hs_q <= 1'b0;
                           st_q <= ST_IDLE;
                        end
                     endcase
                  end
               end
               ST_LOST: begin
                  SCL_OE <= 1'b0;
                  SDA_OE <= 1'b0;
                  if (BUS_STATE == `IMTC_BUS_IDLE) begin
                     st_q <= ST_IDLE;
                  end
               end
               default: st_q <= ST_IDLE;
            endcase
            // Unexpected start or stop during our own transfer.
            if ((start_det || stop_det) && st_q != ST_START && st_q != ST_STOP
                && st_q != ST_IDLE && st_q != ST_WAIT && st_q != ST_LOST) begin
               BUS_ERROR <= 1'b1;
               ARB_LOST <= 1'b1;
               MASTER_ON_BUS <= 1'b1;
               SCL_OE <= 1'b0;
               SDA_OE <= 1'b0;
               st_q <= ST_LOST;
            end
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge CLK) begin
      if (RST) begin
         scl_p <= 1'b1;
         sda_p <= 1'b1;
         BUS_STATE <= `IMTC_BUS_UNKNOWN;
         SCL_OUT <= 1'b0;
         SDA_OUT <= 1'b0;
         RX_VALID <= 1'b0;
         RX_DATA <= '0;
      end else begin
         scl_p <= scl_s;
         sda_p <= sda_s;
         if (rx_or) begin
            RX_VALID <= rx_ov;
            RX_DATA <= rx_od;
         end
         if (st_q == ST_LOST && BUS_STATE == `IMTC_BUS_BUS_OWNED_STATE) begin
            BUS_STATE <= `IMTC_BUS_BUSY;
         end else if (st_q == ST_START && BUS_STATE != `IMTC_BUS_BUS_OWNED_STATE) begin
            BUS_STATE <= `IMTC_BUS_BUS_OWNED_STATE;
         end else if (stop_det) begin
            BUS_STATE <= `IMTC_BUS_IDLE;
         end else if (start_det && BUS_STATE != `IMTC_BUS_BUS_OWNED_STATE) begin
            BUS_STATE <= `IMTC_BUS_BUSY;
         end
      end
   end
endmodule
`default_nettype wire

//--- verif/imtc_top_sva.sv
`timescale 1ns/100ps
`default_nettype none
`include "imtc_cfg.svh"
module imtc_top_sva (
   input wire logic CLK,
   input wire logic RST,
   input wire logic SCL_OE,
   input wire logic SDA_OE,
   input wire logic ADDR_WRITE,
   input wire logic TX_VALID,
   input wire logic CMD_WRITE,
   input wire logic RX_VALID,
   input wire logic RX_READY,
   input wire logic [7:0] RX_DATA,
   input wire logic MASTER_ON_BUS,
   input wire logic SLAVE_ON_BUS,
   input wire logic ARB_LOST,
   input wire logic BUS_ERROR,
   input wire logic RX_NACK,
   input wire logic [1:0] BUS_STATE
);
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   ////////////////////////////////////////////////////////////
   // Four quiet cycles are required so that a flag still clearing after a take
   // is not mistaken for a hold that was dropped.
   sequence held_s;
      ((MASTER_ON_BUS || SLAVE_ON_BUS) && !ARB_LOST && !TX_VALID && !CMD_WRITE && !ADDR_WRITE) [*4];
   endsequence
   sequence start_s;
      ADDR_WRITE && BUS_STATE == `IMTC_BUS_IDLE;
   endsequence
   sequence lost_s;
      ARB_LOST && $past(ARB_LOST) && !ADDR_WRITE;
   endsequence
   hold_scl_a: assert property (held_s |-> SCL_OE)
      else $error("clock hold dropped");
   addr_clear_a: assert property (ADDR_WRITE |=> !(MASTER_ON_BUS || SLAVE_ON_BUS || ARB_LOST
      || BUS_ERROR || RX_NACK)) else $error("flags kept after address write");
   bus_error_status_arb_a: assert property (BUS_ERROR |-> ARB_LOST && MASTER_ON_BUS)
      else $error("bus error without lost status");
   lost_flag_a: assert property ($rose(ARB_LOST) |-> MASTER_ON_BUS)
      else $error("lost without master flag");
   lost_quiet_a: assert property (lost_s |-> !SDA_OE && !SCL_OE)
      else $error("lines driven after loss");
   nack_flag_a: assert property ($rose(RX_NACK) |-> ##[0:60] MASTER_ON_BUS)
      else $error("nack without master flag");
   slave_flag_a: assert property ($rose(SLAVE_ON_BUS) |-> !RX_NACK && !ARB_LOST)
      else $error("slave flag with bad status");
   bus_owned_state_state_a: assert property (start_s |-> ##[1:40] BUS_STATE == `IMTC_BUS_BUS_OWNED_STATE)
      else $error("bus state not bus_owned_state");
   rx_stall_a: assert property (RX_VALID && !RX_READY |=> RX_VALID && $stable(RX_DATA))
      else $error("received byte lost in stall");
endmodule
bind imtc_top imtc_top_sva chk_u (.CLK(CLK), .RST(RST), .SCL_OE(SCL_OE), .SDA_OE(SDA_OE),
   .ADDR_WRITE(ADDR_WRITE), .TX_VALID(TX_VALID), .CMD_WRITE(CMD_WRITE), .RX_VALID(RX_VALID),
   .RX_READY(RX_READY), .RX_DATA(RX_DATA), .MASTER_ON_BUS(MASTER_ON_BUS),
   .SLAVE_ON_BUS(SLAVE_ON_BUS), .ARB_LOST(ARB_LOST), .BUS_ERROR(BUS_ERROR), .RX_NACK(RX_NACK),
   .BUS_STATE(BUS_STATE));
`default_nettype wire

//--- verif/imtc_slave_model.sv
`timescale 1ns/100ps
`default_nettype none
module imtc_slave_model #(
   parameter logic [6:0] SADR = 7'h2a
) (
   input wire logic scl,
   input wire logic sda,
   input wire logic [7:0] rd_byte,
   output logic sda_oe = 1'b0,
   output logic [7:0] got = 8'h00
);
   int bits = 0;
   logic [7:0] sh = 8'h00;
   logic addr_ph = 1'b0, rd_ph = 1'b0, acked = 1'b0, mack = 1'b1;
   ////////////////////////////////////////////////////////////
   // A start or repeated start makes the next byte an address.
   always @(negedge sda) if (scl) begin
      bits = 0;
      addr_ph = 1'b1;
      rd_ph = 1'b0;
      sda_oe = 1'b0;
   end
   always @(posedge scl) begin
      if (bits < 8) sh = {sh[6:0], sda};
      if (bits == 8) mack = sda;
      bits = bits + 1;
   end
   // Data only changes while the clock is low; the line is released otherwise,
   // so the pull-up, not a stale value, is what the master sees.
   always @(negedge scl) begin
      if (bits == 8) begin
         got = sh;
         acked = !rd_ph && (!addr_ph || sh[7:1] == SADR);
         sda_oe = acked;
      end else if (bits == 9) begin
         rd_ph = addr_ph ? (acked && sh[0]) : (rd_ph && !mack);
         addr_ph = 1'b0;
         bits = 0;
         sda_oe = rd_ph && !rd_byte[7];
      end else if (rd_ph && bits > 0) begin
         sda_oe = !rd_byte[7 - bits];
      end
   end
endmodule
`default_nettype wire

//--- verif/imtc_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "imtc_cfg.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_total++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module imtc_top_tb;
   import imtc_pkg::*;
   localparam logic [6:0] SADR = 7'h2a;
   logic clk = 1'b0, rst = 1'b1, aw = 1'b0, ahs = 1'b0, ten = 1'b0, txv = 1'b0, rxr = 1'b0;
   logic cw = 1'b0, jam = 1'b0, sm = 1'b0, acknowledge_action = 1'b0, smart_mode_enable = 1'b0;
   logic [1:0] spd = 2'h0;
   logic [7:0] hs_hi = 8'h03, hs_lo = 8'h07, txd = 8'h00, rd = 8'h00, seed = 8'h4f;
   logic [10:0] av = 11'h000;
   imtc_cmd_t cmd = `IMTC_CMD_NONE;
   logic scl_oe, sda_oe, scl_o, sda_o, m_oe, txr, rxv, mb, sb, al, be, rn;
   logic [7:0] got, rxd;
   logic [1:0] bst;
   int err_total = 0, comparisons = 0, cyc = 0;
   wire logic scl = !scl_oe;
   wire logic sda = !(sda_oe || m_oe || jam);
   imtc_top #(.BAUD_W(8), .FS_HALF(2)) dut_u (.CLK(clk), .RST(rst), .SCL_IN(scl),
      .SCL_OUT(scl_o), .SCL_OE(scl_oe), .SDA_IN(sda), .SDA_OUT(sda_o), .SDA_OE(sda_oe),
      .HS_BAUD_HIGH(hs_hi), .HS_BAUD_LOW_A(hs_lo), .SPEED_SELECT(spd), .STRETCH_MODE(sm),
      .SMART_MODE(smart_mode_enable), .ACK_ACTION(acknowledge_action), .ADDR_WRITE(aw), .ADDR_VALUE(av),
      .HIGH_SPEED_ADDRESS_BIT(ahs), .TEN_BIT_EN(ten), .TX_VALID(txv), .TX_READY(txr), .TX_DATA(txd),
      .RX_VALID(rxv), .RX_READY(rxr), .RX_DATA(rxd), .CMD_WRITE(cw), .CMD(cmd),
      .MASTER_ON_BUS(mb), .SLAVE_ON_BUS(sb), .ARB_LOST(al), .BUS_ERROR(be), .RX_NACK(rn),
      .BUS_STATE(bst));
   imtc_slave_model #(.SADR(SADR)) peer_u (.scl(scl), .sda(sda), .rd_byte(rd),
      .sda_oe(m_oe), .got(got));
   ////////////////////////////////////////////////////////////
   always #12.5 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         err_total++;
         final_report();
      end
   end
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   function automatic int hs_period(input int h, input int l);
      return (l == 0) ? 2 + 2 * h : 2 + h + l;
   endfunction
   task automatic final_report;
      $display("comparisons=%0d err_total=%0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wait_flag;
      for (int n = 0; n < 4000 && !(mb || sb || al); n++) tick(1);
   endtask
   task automatic addr(input logic [10:0] v, input logic hs, input logic tb10);
      av = v;
      ahs = hs;
      ten = tb10;
      aw = 1'b1;
      tick(1);
      aw = 1'b0;
      `CHK({mb, sb, al, be, rn}, 5'h00)
   endtask
   // Flags clear on the taking edge; two spare cycles keep the next wait honest.
   task automatic command(input imtc_cmd_t c);
      cmd = c;
      cw = 1'b1;
      tick(1);
      cw = 1'b0;
      tick(2);
   endtask
   task automatic send(input logic [7:0] d);
      txd = d;
      txv = 1'b1;
      for (int n = 0; n < 400; n++) begin
         tick(1);
         if (txr) break;
      end
      tick(1);
      txv = 1'b0;
      tick(2);
   endtask
   task automatic stop_idle;
      command(`IMTC_CMD_STOP);
      for (int n = 0; n < 400 && bst !== `IMTC_BUS_IDLE; n++) tick(1);
      `CHK(bst, `IMTC_BUS_IDLE)
   endtask
   task automatic hs_run(input logic [7:0] h, input logic [7:0] l);
      int t[6];
      int k;
      logic p;
      hs_hi = h;
      hs_lo = l;
      spd = `IMTC_SPEED_HS;
      sm = 1'b1;
      addr(11'h00b, 1'b0, 1'b0);
      wait_flag();
      `CHK({mb, rn}, 2'b11)
      addr({SADR, 1'b0}, 1'b1, 1'b0);
      k = 0;
      p = scl_oe;
      for (int n = 0; n < 2000 && k < 6; n++) begin
         @(posedge clk);
         if (scl_oe && !p) t[k++] = n;
         p = scl_oe;
      end
      #1;
      `CHK(t[5] - t[4], hs_period(h, l))
      wait_flag();
      `CHK({mb, rn}, 2'b10)
      stop_idle();
      spd = 2'h0;
   endtask
   initial begin
      tick(12);
      `CHK({mb, sb, al, be, rn, bst, scl_oe, sda_oe}, 9'h000)
      rst = 1'b0;
      addr({SADR, 1'b0}, 1'b0, 1'b0);
      wait_flag();
      `CHK({mb, sb, rn, scl_oe}, 4'b1001)
      for (int i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         `CHK(rn, 1'b0)
         send(seed);
         wait_flag();
         `CHK(got, seed)
         `CHK({mb, al, rn}, 3'b100)
      end
      stop_idle();
      addr({7'h11, 1'b0}, 1'b0, 1'b0);
      wait_flag();
      `CHK({mb, rn}, 2'b11)
      `CHK(bst, `IMTC_BUS_BUS_OWNED_STATE)
      tick(30);
      `CHK({mb, scl_oe}, 2'b11)
      addr({SADR, 1'b0}, 1'b0, 1'b0);
      wait_flag();
      `CHK({mb, rn}, 2'b10)
      stop_idle();
      seed = lfsr(seed);
      rd = seed;
      addr({SADR, 1'b1}, 1'b0, 1'b0);
      wait_flag();
      tick(1);
      `CHK({sb, rn, rxv}, 3'b101)
      command(`IMTC_CMD_READ);
      wait_flag();
      `CHK({sb, rxv}, 2'b11)
      rxr = 1'b1;
      `CHK(rxd, rd)
      tick(1);
      `CHK(rxd, rd)
      tick(1);
      `CHK(rxv, 1'b0)
      acknowledge_action = 1'b1;
      stop_idle();
      // Jamming only after the start keeps the bus from looking busy beforehand.
      addr({SADR, 1'b0}, 1'b0, 1'b0);
      for (int n = 0; n < 400 && !scl_oe; n++) tick(1);
      jam = 1'b1;
      wait_flag();
      tick(4);
      `CHK(al, 1'b1)
      `CHK({mb, al, sda_oe, scl_oe}, 4'b1100)
      jam = 1'b0;
      for (int n = 0; n < 400 && bst !== `IMTC_BUS_IDLE; n++) tick(1);
      `CHK(bst, `IMTC_BUS_IDLE)
      addr({10'h2a5, 1'b0}, 1'b0, 1'b1);
      wait_flag();
      `CHK(got, {5'h1e, 2'b10, 1'b0})
      `CHK({mb, rn}, 2'b11)
      addr({3'b000, 5'h1e, 2'b10, 1'b1}, 1'b0, 1'b0);
      wait_flag();
      `CHK(got, {5'h1e, 2'b10, 1'b1})
      `CHK({mb, rn}, 2'b11)
      stop_idle();
      hs_run(8'h03, 8'h07);
      hs_run(8'h04, 8'h00);
      final_report();
   end
endmodule
`default_nettype wire
